// ===== src/gimd_pkg.sv
// constants for the bus interface message decoder
package gimd_pkg;
  // command byte classes: bits 6:4 split addressed from universal codes,
  // the upper two of them pick the listen address group
  localparam logic [2:0] GIMD_GRP_ACG = 3'h0;
  localparam logic [2:0] GIMD_GRP_UCG = 3'h1;
  localparam logic [1:0] GIMD_GRP_LAG = 2'h1;
  // secondary byte 60..6F after PPC enables a parallel poll response
  localparam logic [2:0] GIMD_GRP_PPE = 3'h6;
  localparam int         GIMD_GRP_HI  = 6;
  localparam int         GIMD_GRP_LO  = 4;
  // top bit of the address field in a listen address byte
  localparam int         GIMD_FLD_HI  = 4;
  // addressed commands (00..0F)
  localparam logic [7:0] GIMD_CMD_GTL = 8'h01;
  localparam logic [7:0] GIMD_CMD_SDC = 8'h04;
  localparam logic [7:0] GIMD_CMD_PPC = 8'h05;
  localparam logic [7:0] GIMD_CMD_GET = 8'h08;
  localparam logic [7:0] GIMD_CMD_GTR = 8'h09;
  // universal commands (10..1F), then unlisten (3F)
  localparam logic [7:0] GIMD_CMD_LLO = 8'h11;
  localparam logic [7:0] GIMD_CMD_DCL = 8'h14;
  localparam logic [7:0] GIMD_CMD_PPU = 8'h15;
  localparam logic [7:0] GIMD_CMD_SPE = 8'h18;
  localparam logic [7:0] GIMD_CMD_SPD = 8'h19;
  localparam logic [7:0] GIMD_CMD_UNL = 8'h3F;
  // bus address limits and factory default
  localparam logic [4:0] GIMD_ADDR_MAX     = 5'h1E;
  localparam logic [4:0] GIMD_ADDR_DEFAULT = 5'h1C;
endpackage : gimd_pkg

// ===== src/gimd_addr_reg.sv
// bus address holder with range check
`timescale 1ns/100ps
`default_nettype none
module gimd_addr_reg
  import gimd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       addrWrite,
  input  wire logic [4:0] addrValue,
  output logic      [4:0] busAddr,
  output logic            addrReject
);
  logic [4:0] next_busAddr;
  logic       next_addrReject;

  always_comb begin
    next_busAddr    = busAddr;
    next_addrReject = 1'b0;
    if (addrWrite) begin
      if (addrValue <= GIMD_ADDR_MAX) begin
        next_busAddr = addrValue;
      end else begin
        next_addrReject = 1'b1;
      end
    end
  end

  // only the power-on reset restores the factory value; a settings reset never reaches here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busAddr    <= GIMD_ADDR_DEFAULT;
      addrReject <= 1'b0;
    end else begin
      busAddr    <= next_busAddr;
      addrReject <= next_addrReject;
    end
  end
endmodule : gimd_addr_reg
`default_nettype wire

// ===== src/gimd_decoder.sv
// bus interface message decoder, device side
// Functional notes
// - bytes are commands only while attention low
// - codes 10..1F act without addressing
// - codes 00..0F act only when listening
// - device clear resets parser, keeps settings
// - interface clear line resets bus logic
// - lockout blocks local key until go-local
// - serial poll enable/disable set poll mode
// - PPC configures, PPU drops parallel poll
// - addressed trigger fires like external trigger
// - addressed remote/local commands switch control state
// - address accepted 0..30, others rejected
// - address survives settings reset
// - address writable locally or remotely
// - factory default address is 28
`timescale 1ns/100ps
`default_nettype none
module gimd_decoder
  import gimd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] busData,
  input  wire logic       busDataValid,
  input  wire logic       atn_n,
  input  wire logic       ifc_n,
  input  wire logic       localKey,
  input  wire logic       addrWrite,
  input  wire logic [4:0] addrValue,
  output logic      [7:0] devData,
  output logic            devDataValid,
  output logic            listenActive,
  output logic            remoteState,
  output logic            lockoutActive,
  output logic            serialPollMode,
  output logic            parPollConfigured,
  output logic            parserClear,
  output logic            triggerPulse,
  output logic      [4:0] busAddr,
  output logic            addrReject
);
  typedef enum logic [1:0] {
    GIMD_ST_IDLE  = 2'b00,
    GIMD_ST_PPCFG = 2'b01
  } gimd_state_e;

  gimd_state_e state;
  gimd_state_e next_state;
  logic [7:0]  next_devData;
  logic        next_devDataValid;
  logic        next_listenActive;
  logic        next_remoteState;
  logic        next_lockoutActive;
  logic        next_serialPollMode;
  logic        next_parPollConfigured;
  logic        next_parserClear;
  logic        next_triggerPulse;
  logic        cmdStrobe;
  logic [2:0]  cmdGroup;
  logic        dataStrobe;
  logic        univCmd;
  logic        addrCmd;
  logic        listenGrp;
  logic        hitDcl;
  logic        hitLlo;
  logic        hitSpe;
  logic        hitSpd;
  logic        hitPpu;
  logic        hitSdc;
  logic        hitGet;
  logic        hitGtr;
  logic        hitGtl;
  logic        hitPpc;
  logic        hitUnl;
  logic        hitMla;
  logic        hitPpe;
  logic        keyLocal;

  gimd_addr_reg u_addr (
    .clk        (clk),
    .rst_n      (rst_n),
    .addrWrite  (addrWrite),
    .addrValue  (addrValue),
    .busAddr    (busAddr),
    .addrReject (addrReject)
  );

  // bytes are ignored while the interface clear line is held low
  assign cmdStrobe  = busDataValid && !atn_n && ifc_n;
  assign dataStrobe = busDataValid && atn_n && ifc_n;
  assign cmdGroup   = busData[GIMD_GRP_HI:GIMD_GRP_LO];
  assign keyLocal   = localKey && !lockoutActive;

  // byte class under attention; addressed codes only count while listening
  always_comb begin
    univCmd   = 1'b0;
    addrCmd   = 1'b0;
    listenGrp = 1'b0;
    hitPpe    = 1'b0;
    if (cmdStrobe) begin
      univCmd   = (cmdGroup == GIMD_GRP_UCG);
      addrCmd   = (cmdGroup == GIMD_GRP_ACG) && listenActive;
      listenGrp = (cmdGroup[2:1] == GIMD_GRP_LAG);
      hitPpe    = (state == GIMD_ST_PPCFG) && (cmdGroup == GIMD_GRP_PPE);
    end
  end

  // one decode feeds every state group, so no two groups can read a byte differently
  always_comb begin
    hitDcl = 1'b0;
    hitLlo = 1'b0;
    hitSpe = 1'b0;
    hitSpd = 1'b0;
    hitPpu = 1'b0;
    hitSdc = 1'b0;
    hitGet = 1'b0;
    hitGtr = 1'b0;
    hitGtl = 1'b0;
    hitPpc = 1'b0;
    hitUnl = 1'b0;
    hitMla = 1'b0;
    if (univCmd) begin
      hitDcl = (busData == GIMD_CMD_DCL);
      hitLlo = (busData == GIMD_CMD_LLO);
      hitSpe = (busData == GIMD_CMD_SPE);
      hitSpd = (busData == GIMD_CMD_SPD);
      hitPpu = (busData == GIMD_CMD_PPU);
    end
    if (addrCmd) begin
      hitSdc = (busData == GIMD_CMD_SDC);
      hitGet = (busData == GIMD_CMD_GET);
      hitGtr = (busData == GIMD_CMD_GTR);
      hitGtl = (busData == GIMD_CMD_GTL);
      hitPpc = (busData == GIMD_CMD_PPC);
    end
    if (listenGrp) begin
      hitUnl = (busData == GIMD_CMD_UNL);
      // the unlisten code never matches an address: addresses stop at 30
      hitMla = (busData[GIMD_FLD_HI:0] == busAddr);
    end
  end

  // parser state: PPC opens a wait for one secondary byte
  always_comb begin
    next_state = state;
    case (state)
      GIMD_ST_IDLE: begin
        if (hitPpc) begin
          next_state = GIMD_ST_PPCFG;
        end
      end
      GIMD_ST_PPCFG: begin
        // any other command byte ends the wait, device clear included
        if (cmdStrobe && !hitPpc) begin
          next_state = GIMD_ST_IDLE;
        end
      end
      default: begin
        next_state = GIMD_ST_IDLE;
      end
    endcase
    // interface clear outranks everything on the bus in the same cycle
    if (!ifc_n) begin
      next_state = GIMD_ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= GIMD_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // listener: own listen address sets it, unlisten or interface clear drops it
  // a listen address for another device leaves this one listening
  always_comb begin
    next_listenActive = listenActive;
    if (!ifc_n) begin
      next_listenActive = 1'b0;
    end else if (hitUnl) begin
      next_listenActive = 1'b0;
    end else if (hitMla) begin
      next_listenActive = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      listenActive <= 1'b0;
    end else begin
      listenActive <= next_listenActive;
    end
  end

  // remote and lockout: interface clear leaves both alone
  always_comb begin
    next_remoteState   = remoteState;
    next_lockoutActive = lockoutActive;
    if (hitLlo) begin
      next_lockoutActive = 1'b1;
    end
    if (hitGtr) begin
      next_remoteState = 1'b1;
    end
    if (hitGtl) begin
      next_remoteState   = 1'b0;
      next_lockoutActive = 1'b0;
    end
    // the key, unless locked out, wins over a remote command in the same cycle: the operator has the last word
    if (keyLocal) begin
      next_remoteState = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remoteState   <= 1'b0;
      lockoutActive <= 1'b0;
    end else begin
      remoteState   <= next_remoteState;
      lockoutActive <= next_lockoutActive;
    end
  end

  // poll states; only the serial one is part of the interface reset
  always_comb begin
    next_serialPollMode    = serialPollMode;
    next_parPollConfigured = parPollConfigured;
    if (!ifc_n) begin
      next_serialPollMode = 1'b0;
    end
    if (hitSpe) begin
      next_serialPollMode = 1'b1;
    end
    if (hitSpd) begin
      next_serialPollMode = 1'b0;
    end
    if (hitPpe) begin
      next_parPollConfigured = 1'b1;
    end
    if (hitPpu) begin
      next_parPollConfigured = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serialPollMode    <= 1'b0;
      parPollConfigured <= 1'b0;
    end else begin
      serialPollMode    <= next_serialPollMode;
      parPollConfigured <= next_parPollConfigured;
    end
  end

  // one-cycle pulses towards the command parser and the trigger system
  always_comb begin
    next_parserClear  = 1'b0;
    next_triggerPulse = 1'b0;
    if (hitDcl || hitSdc) begin
      // settings are not touched; only the parser hears the clear
      next_parserClear = 1'b1;
    end
    if (hitGet) begin
      next_triggerPulse = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      parserClear  <= 1'b0;
      triggerPulse <= 1'b0;
    end else begin
      parserClear  <= next_parserClear;
      triggerPulse <= next_triggerPulse;
    end
  end

  // device data: the byte is kept, the strobe only reaches the user while listening
  // all eight lines pass through, so eight-bit data survives
  always_comb begin
    next_devData      = devData;
    next_devDataValid = 1'b0;
    if (dataStrobe) begin
      next_devData      = busData;
      next_devDataValid = listenActive;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      devData      <= 8'h00;
      devDataValid <= 1'b0;
    end else begin
      devData      <= next_devData;
      devDataValid <= next_devDataValid;
    end
  end
endmodule : gimd_decoder
`default_nettype wire

// ===== tb/gimd_checker.sv
// port assertions for the bus message decoder
`timescale 1ns/100ps
`default_nettype none
module gimd_checker
  import gimd_pkg::*;
(
  input wire logic       clk, rst_n, busDataValid, atn_n, ifc_n, addrWrite, localKey,
  input wire logic       listenActive, serialPollMode, parPollConfigured, remoteState,
  input wire logic       lockoutActive, devDataValid,
  input wire logic       parserClear, triggerPulse, addrReject,
  input wire logic [7:0] busData,
  input wire logic [4:0] addrValue, busAddr
);
  wire logic cmd = busDataValid & ~atn_n & ifc_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_get_fires: assert property (
    cmd && busData == GIMD_CMD_GET && listenActive |=> triggerPulse) else $error("no trigger");
  a_atn_data: assert property (
    busDataValid && atn_n |=> !parserClear && !triggerPulse) else $error("data as command");
  a_dcl_clear: assert property (
    cmd && busData == GIMD_CMD_DCL |=> parserClear) else $error("no parser clear");
  a_spe_mode: assert property (
    cmd && busData == GIMD_CMD_SPE |=> serialPollMode) else $error("no poll mode");
  a_ppu_drop: assert property (
    cmd && busData == GIMD_CMD_PPU |=> !parPollConfigured) else $error("poll config kept");
  a_ifc_reset: assert property (
    !ifc_n |=> !listenActive && !serialPollMode) else $error("clear line ignored");
  a_listen_set: assert property (
    cmd && busData == {3'h1, busAddr} |=> listenActive) else $error("not listening");
  a_addr_rej: assert property (
    addrWrite && addrValue > GIMD_ADDR_MAX |=> addrReject && $stable(busAddr)) else $error("bad addr");
  a_addr_take: assert property (
    addrWrite && addrValue <= GIMD_ADDR_MAX |=> busAddr == $past(addrValue)) else $error("addr lost");
  a_unaddr_ignore: assert property (
    cmd && busData[7:4] == 4'h0 && !listenActive |=> !triggerPulse && !parserClear)
    else $error("addressed command taken while not listening");
  a_lock_hold: assert property (
    remoteState && lockoutActive && !cmd |=> remoteState) else $error("lockout broken");
  a_gtr_remote: assert property (
    cmd && busData == GIMD_CMD_GTR && listenActive && !localKey |=> remoteState)
    else $error("no remote state");
  a_data_listen: assert property (
    busDataValid && atn_n && ifc_n |=> devDataValid == $past(listenActive))
    else $error("data strobe wrong");
  a_addr_hold: assert property (
    !addrWrite |=> $stable(busAddr)) else $error("address changed unasked");
endmodule : gimd_checker
bind gimd_decoder gimd_checker chk_i (.clk, .rst_n, .busDataValid, .atn_n, .ifc_n, .addrWrite,
  .localKey, .listenActive, .serialPollMode, .parPollConfigured, .remoteState, .lockoutActive,
  .devDataValid, .parserClear, .triggerPulse, .addrReject, .busData, .addrValue, .busAddr);
`default_nettype wire

// ===== tb/gimd_ctrl_model.sv
// bus controller model sending command and data bytes
`timescale 1ns/100ps
`default_nettype none
module gimd_ctrl_model (
  input  wire logic       clk,
  output logic      [7:0] busData = 8'h00,
  output logic            busDataValid = 1'b0,
  output logic            atn_n = 1'b1,
  output logic            ifc_n = 1'b1
);
  // idle lines show the inverse so a stale byte never looks valid
  task automatic send(input logic [7:0] b, input logic isCmd);
    @(posedge clk);
    busData <= b;
    atn_n <= ~isCmd;
    busDataValid <= 1'b1;
    @(posedge clk);
    busData <= ~b;
    atn_n <= 1'b1;
    busDataValid <= 1'b0;
  endtask : send
  task automatic clear();
    @(posedge clk) ifc_n <= 1'b0;
    @(posedge clk) ifc_n <= 1'b1;
  endtask : clear
endmodule : gimd_ctrl_model
`default_nettype wire

// ===== tb/gimd_decoder_bench.sv
// self-checking bench for the bus message decoder
`timescale 1ns/100ps
`default_nettype none
module gimd_decoder_bench;
  import gimd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, localKey = 1'b0, addrWrite = 1'b0;
  logic [4:0] addrValue = 5'h00, busAddr;
  logic [7:0] busData, devData;
  logic busDataValid, atn_n, ifc_n, devDataValid, listenActive, remoteState, lockoutActive;
  logic serialPollMode, parPollConfigured, parserClear, triggerPulse, addrReject;
  int fails = 0, total_checks = 0;
  always #4 clk = ~clk;
  gimd_ctrl_model ctl (.clk, .busData, .busDataValid, .atn_n, .ifc_n);
  gimd_decoder dut (.clk, .rst_n, .busData, .busDataValid, .atn_n, .ifc_n, .localKey,
    .addrWrite, .addrValue, .devData, .devDataValid, .listenActive, .remoteState,
    .lockoutActive, .serialPollMode, .parPollConfigured, .parserClear, .triggerPulse,
    .busAddr, .addrReject);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic listen_trig();
    ctl.send(GIMD_CMD_GET, 1'b1);
    #1 chk(triggerPulse, 8'h00);
    ctl.send(8'h3C, 1'b1);
    #1 chk(listenActive, 8'h01);
    ctl.send(GIMD_CMD_GET, 1'b1);
    #1 chk(triggerPulse, 8'h01);
    ctl.send(8'hA5, 1'b0);
    #1 chk(devData, 8'hA5);
    chk({devDataValid, parserClear}, 8'h02);
    ctl.send(GIMD_CMD_GTR, 1'b1);
    #1 chk(remoteState, 8'h01);
    @(posedge clk) localKey <= 1'b1;
    @(posedge clk) localKey <= 1'b0;
    #1 chk(remoteState, 8'h00);
    ctl.send(GIMD_CMD_GTR, 1'b1);
  endtask : listen_trig
  task automatic lock_local();
    ctl.send(GIMD_CMD_LLO, 1'b1);
    @(posedge clk) localKey <= 1'b1;
    @(posedge clk) localKey <= 1'b0;
    #1 chk({lockoutActive, remoteState}, 8'h03);
    ctl.send(GIMD_CMD_GTL, 1'b1);
    #1 chk({lockoutActive, remoteState}, 8'h00);
  endtask : lock_local
  task automatic polls();
    ctl.send(GIMD_CMD_SPE, 1'b1);
    #1 chk(serialPollMode, 8'h01);
    ctl.send(GIMD_CMD_SPD, 1'b1);
    #1 chk(serialPollMode, 8'h00);
    ctl.send(GIMD_CMD_SPE, 1'b1);
    ctl.send(GIMD_CMD_PPC, 1'b1);
    ctl.send(8'h65, 1'b1);
    #1 chk(parPollConfigured, 8'h01);
    ctl.send(GIMD_CMD_DCL, 1'b1);
    #1 chk({parserClear, parPollConfigured}, 8'h03);
    chk(busAddr, GIMD_ADDR_DEFAULT);
    ctl.clear();
    #1 chk({listenActive, serialPollMode, parPollConfigured}, 8'h01);
    ctl.send(GIMD_CMD_PPU, 1'b1);
    #1 chk(parPollConfigured, 8'h00);
  endtask : polls
  task automatic addr_set(input logic [4:0] v, input logic [4:0] exp, input logic rej);
    @(posedge clk) addrWrite <= 1'b1;
    addrValue <= v;
    @(posedge clk) addrWrite <= 1'b0;
    #1 chk({addrReject, busAddr}, {rej, exp});
  endtask : addr_set
  task automatic addresses();
    addr_set(5'h12, 5'h12, 1'b0);
    addr_set(5'h1F, 5'h12, 1'b1);
    addr_set(5'h1E, 5'h1E, 1'b0);
    addr_set(5'h00, 5'h00, 1'b0);
    ctl.send(8'h20, 1'b1);
    #1 chk(listenActive, 8'h01);
    ctl.send(GIMD_CMD_UNL, 1'b1);
    #1 chk(listenActive, 8'h00);
    ctl.send(8'h5A, 1'b0);
    #1 chk(devData, 8'h5A);
    chk(devDataValid, 8'h00);
  endtask : addresses
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(busAddr, GIMD_ADDR_DEFAULT);
    listen_trig();
    lock_local();
    polls();
    addresses();
    end_sim();
  end
endmodule : gimd_decoder_bench
`default_nettype wire
